/* File: sbcm_pkg.sv */
// Constants and types for the mode controller and its serial port
package sbcm_pkg;
  // Operating modes, one-hot
  typedef enum logic [4:0] {
    M_OFF = 5'h01,
    M_STBY = 5'h02,
    M_NORM = 5'h04,
    M_SLP = 5'h08,
    M_OTP = 5'h10
  } sbcm_mode_t;
  // Register addresses carried in frame bits 15:13
  localparam logic [2:0] A_WDS = 3'h0;
  localparam logic [2:0] A_MODE = 3'h1;
  localparam logic [2:0] A_IEN = 3'h2;
  localparam logic [2:0] A_IFL = 3'h3;
  localparam int N_REGS = 4;
  // Frame layout
  localparam int FRAME_BITS = 16;
  localparam int HDR_BITS = 4;
  localparam int DATA_BITS = 12;
  localparam int ADDR_LSB = 13;
  localparam int RO_BIT = 12;
  // watchdog_and_status fields
  localparam int WMC_BIT = 11;
  localparam int WP_LSB = 8;
  localparam int WOS_BIT = 7;
  localparam logic [2:0] WP_DEF = 3'h4;
  // operating_mode_control fields
  localparam int MS_LSB = 10;
  localparam int LHC_BIT = 8;
  localparam int STBC_LSB = 0;
  localparam int STBC_CAN = 2;
  localparam int STBC_L1 = 1;
  localparam int STBC_L2 = 0;
  localparam logic [1:0] MS_STBY = 2'h0;
  localparam logic [1:0] MS_SLP = 2'h1;
  // Wake source order in enable and flag registers
  localparam int WK_LOC = 0;
  localparam int WK_LIN = 1;
  localparam int WK_CAN = 2;
  localparam int WK_N = 3;
  // Transceiver and watchdog states
  localparam logic [1:0] XC_OFF = 2'h0;
  localparam logic [1:0] XC_LP = 2'h1;
  localparam logic [1:0] XC_ACT = 2'h2;
  localparam logic [1:0] WD_OFF = 2'h0;
  localparam logic [1:0] WD_TO = 2'h1;
  localparam logic [1:0] WD_WIN = 2'h2;
  // Pin input vector positions
  localparam int IN_POFF = 0;
  localparam int IN_OTA = 1;
  localparam int IN_OTR = 2;
  localparam int IN_WATCHDOG_DISABLE_PIN = 3;
  localparam int IN_LOCW = 4;
  localparam int IN_LINW = 5;
  localparam int IN_CANW = 6;
  localparam int IN_RST = 7;
  localparam int N_IN = 8;
  // Timing
  localparam real SHORT_RST_MS = 3.6;
  localparam real CLK_MHZ = 50.0;
  localparam int SHORT_RST_CYC = int'($ceil(SHORT_RST_MS * CLK_MHZ * 1000.0));
  localparam logic [1:0] SETTLE_CYC = 2'h3;
endpackage

/* File: sbcm_mode_ctrl.sv */
// Mode controller with serial register port
// What this block does
// - Battery low forces Off, regulators off, hiz
// - Wake event moves Sleep to Standby
// - Normal to Standby by select 00 or reset
// - Standby: main regulator up, transceivers low-power/off
// - Standby watchdog timeout or off per pin/bit
// - Standby select 10/11 enters Normal, CAN regulator
// - Overtemperature moves Standby to Overtemp
// - Normal CAN transceiver active or low-power
// - Normal LIN transceivers active or low-power
// - Overtemperature moves Normal to Overtemp
// - Select 01 enters Sleep when conditions hold
// - Refused Sleep gives reset of 3.6 ms
// - Sleep: regulators off, transceivers off/low-power
// - Sleep: watchdog stopped, reset held low
// - Sleep wake: Standby, reset, select cleared
// - Overtemp entry: reset low, limp control set
// - Overtemp: regulators off, buses hiz
// - Temperature release: Standby plus system reset
// - Serial port is full duplex
// - Select active low, output floats deselected
// - Sample falling edge, change rising edge
// - Bits 15:13 address, 11:0 contents
// - Bit 12 set reads without writing
// - Watchdog mode bit picks window/timeout/off
// - Period code doubles from 8 ms
// - Any reset restores period code 100, except an external one in Standby, which is ignored
module sbcm_mode_ctrl #(
  parameter int RST_CYC = sbcm_pkg::SHORT_RST_CYC
) (
  input wire logic clk_sys, // System clock
  input wire logic arst_n, // Async reset
  input wire logic spi_sclk, // Serial clock
  input wire logic serial_select_n, // Chip select
  input wire logic serial_in, // Serial data in
  output logic serial_out, // Serial data out
  output logic serial_out_en_n, // Low while driving
  input wire logic battery_poff, // Battery below off level
  input wire logic otp_act, // Overtemp activation
  input wire logic otp_rel, // Overtemp release
  input wire logic watchdog_disable_pin, // Watchdog off strap
  input wire logic local_wake, // Local wake detector
  input wire logic lin_wake, // LIN wake detector
  input wire logic can_wake, // CAN wake detector
  input wire logic reset_io_n_i, // Reset pin level
  output logic reset_io_n_o, // Reset pin value
  output logic reset_io_n_oe_n, // Low drives reset
  output logic interrupt_out_n, // Pending interrupt
  output logic main_regulator_en, // Main regulator
  output logic can_regulator_en, // CAN regulator
  output logic [1:0] can_xcvr_state, // CAN transceiver
  output logic [1:0] lin_one_state, // LIN1 transceiver
  output logic [1:0] lin_two_state, // LIN2 transceiver
  output logic bus_hiz, // Bus pins floating
  output logic [1:0] watchdog_mode, // Watchdog mode
  output logic [2:0] watchdog_period, // Period code
  output logic limp_home_n, // Limp output
  output logic [4:0] mode_state // Current mode
);
  localparam int RW = $clog2(RST_CYC + 1);
  localparam int DW = sbcm_pkg::DATA_BITS;
  localparam logic [4:0] FCNT_DONE = 5'(sbcm_pkg::FRAME_BITS);
  localparam logic [4:0] FCNT_OVER = 5'(sbcm_pkg::FRAME_BITS + 1);
  localparam logic [4:0] OCNT_HDR = 5'(sbcm_pkg::HDR_BITS);

  typedef struct packed {
    sbcm_pkg::sbcm_mode_t mode;
    logic [2:0] cs_sy;
    logic cs_lvl;
    logic [sbcm_pkg::N_IN-1:0] s1;
    logic [sbcm_pkg::N_IN-1:0] s2;
    logic [sbcm_pkg::N_IN-1:0] s3;
    logic [sbcm_pkg::N_IN-1:0] lvl;
    logic watchdog_mode_select;
    logic [2:0] wp;
    logic [1:0] msel;
    logic limp;
    logic [2:0] stbc;
    logic [2:0] wken;
    logic [2:0] flg;
    logic can_en;
    logic [RW-1:0] rcnt;
    logic [1:0] settle;
    logic [sbcm_pkg::N_REGS*DW-1:0] snap;
  } sbcm_state_t;

  sbcm_state_t st_ff;
  sbcm_state_t nxt_st;
  logic [15:0] in_sr_ff;
  logic [4:0] fcnt_ff;
  logic arm_in_ff;
  logic [15:0] out_sr_ff;
  logic [4:0] ocnt_ff;
  logic arm_out_ff;
  logic sel_idle;
  logic [sbcm_pkg::N_IN-1:0] pin_in;
  logic [2:0] wk_evt;
  logic fr_end;
  logic wr;
  logic ms_wr;
  logic [1:0] ms;
  logic [2:0] addr;
  logic [DW-1:0] din;
  logic sys_rst;
  logic sleep_req;
  logic sleep_ok;
  logic irq_pend;
  logic drive;
  logic ext_rst;
  logic poff;
  logic ota;

  // Transceiver state from mode and its standby bit
  function automatic logic [1:0] xc(input sbcm_pkg::sbcm_mode_t m, input logic sb);
    if (m == sbcm_pkg::M_OFF || m == sbcm_pkg::M_OTP)
      return sbcm_pkg::XC_OFF;
    else if (sb)
      return sbcm_pkg::XC_LP;
    else if (m == sbcm_pkg::M_NORM)
      return sbcm_pkg::XC_ACT;
    else
      return sbcm_pkg::XC_OFF;
  endfunction

  // Wake detector bits in register order
  function automatic logic [2:0] wk_of(input logic [sbcm_pkg::N_IN-1:0] v);
    return {v[sbcm_pkg::IN_CANW], v[sbcm_pkg::IN_LINW], v[sbcm_pkg::IN_LOCW]};
  endfunction

  // Register contents as seen by a read
  function automatic logic [DW-1:0] reg_rd(input sbcm_state_t s, input logic [2:0] a);
    logic [DW-1:0] r;
    r = '0;
    case (a)
      sbcm_pkg::A_WDS:
      begin
        r[sbcm_pkg::WMC_BIT] = s.watchdog_mode_select;
        r[sbcm_pkg::WP_LSB +: 3] = s.wp;
        r[sbcm_pkg::WOS_BIT] = s.lvl[sbcm_pkg::IN_WATCHDOG_DISABLE_PIN];
      end
      sbcm_pkg::A_MODE:
      begin
        r[sbcm_pkg::MS_LSB +: 2] = s.msel;
        r[sbcm_pkg::LHC_BIT] = s.limp;
        r[sbcm_pkg::STBC_LSB +: 3] = s.stbc;
      end
      sbcm_pkg::A_IEN: r[sbcm_pkg::WK_N-1:0] = s.wken;
      sbcm_pkg::A_IFL: r[sbcm_pkg::WK_N-1:0] = s.flg;
      default: r = '0;
    endcase
    return r;
  endfunction

  // Serial domain: sample on falling edge, MSB first
  assign sel_idle = serial_select_n | ~arst_n;

  always_ff @(negedge spi_sclk or posedge sel_idle)
  begin
    if (sel_idle)
      arm_in_ff <= 1'b1;
    else
      arm_in_ff <= 1'b0;
  end

  // Shift register and bit count survive deselect for the commit
  always_ff @(negedge spi_sclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      in_sr_ff <= 16'h0000;
      fcnt_ff <= 5'h00;
    end
    else
    begin
      in_sr_ff <= {in_sr_ff[14:0], serial_in};
      if (arm_in_ff)
        fcnt_ff <= 5'h01;
      else if (fcnt_ff != FCNT_OVER)
        fcnt_ff <= fcnt_ff + 5'h01;
    end
  end

  always_ff @(posedge spi_sclk or posedge sel_idle)
  begin
    if (sel_idle)
      arm_out_ff <= 1'b1;
    else
      arm_out_ff <= 1'b0;
  end

  // Output shifts on rising edge, so bit 15 must still stand at the first
  // falling edge; header echoes the previous frame, contents follow from
  // the register just addressed
  always_ff @(posedge spi_sclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      out_sr_ff <= 16'h0000;
      ocnt_ff <= 5'h00;
    end
    else if (arm_out_ff)
    begin
      out_sr_ff <= {in_sr_ff[15:12], 12'h000};
      ocnt_ff <= 5'h01;
    end
    else
    begin
      if (ocnt_ff != FCNT_OVER)
        ocnt_ff <= ocnt_ff + 5'h01;
      if (ocnt_ff == OCNT_HDR)
        out_sr_ff <= {reg_snap(in_sr_ff[3:1]), 4'h0};
      else
        out_sr_ff <= {out_sr_ff[14:0], 1'b0};
    end
  end

  // Snapshot read; frozen in the system domain while selected
  function automatic logic [DW-1:0] reg_snap(input logic [2:0] a);
    if (a < 3'(sbcm_pkg::N_REGS))
      return st_ff.snap[a * DW +: DW];
    else
      return '0;
  endfunction

  // First bit is ready before the first rising edge
  assign serial_out = arm_out_ff ? in_sr_ff[15] : out_sr_ff[15];
  assign serial_out_en_n = serial_select_n;

  assign pin_in = {reset_io_n_i, can_wake, lin_wake, local_wake,
                   watchdog_disable_pin, otp_rel, otp_act, battery_poff};

  // Decodes shared by the next-state logic and outputs
  assign poff = st_ff.lvl[sbcm_pkg::IN_POFF];
  assign ota = st_ff.lvl[sbcm_pkg::IN_OTA];
  assign irq_pend = |(st_ff.flg & st_ff.wken);
  assign drive = (st_ff.rcnt != '0) || st_ff.mode == sbcm_pkg::M_SLP ||
                 st_ff.mode == sbcm_pkg::M_OTP || st_ff.mode == sbcm_pkg::M_OFF;
  // Own drive is read back late: the settle count runs out one edge before
  // the filtered level catches up, so the third stage must show low as well
  assign ext_rst = !drive && st_ff.settle == 2'h0 && !st_ff.lvl[sbcm_pkg::IN_RST]
                   && !st_ff.s3[sbcm_pkg::IN_RST];
  assign sleep_ok = !irq_pend && !(|wk_of(st_ff.lvl)) && (|st_ff.wken);

  // Next state of the whole system domain
  always_comb
  begin
    nxt_st = st_ff;
    sys_rst = 1'b0;
    sleep_req = 1'b0;
    // Three stages; a change counts once stages two and three agree
    nxt_st.cs_sy = {st_ff.cs_sy[1:0], serial_select_n};
    if (st_ff.cs_sy[1] == st_ff.cs_sy[2])
      nxt_st.cs_lvl = st_ff.cs_sy[2];
    nxt_st.s1 = pin_in;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
    nxt_st.lvl = (st_ff.s2 & st_ff.s3) | (st_ff.lvl & (st_ff.s2 | st_ff.s3));
    wk_evt = wk_of(nxt_st.lvl) & ~wk_of(st_ff.lvl);
    // Serial words are static once deselect is seen here
    fr_end = nxt_st.cs_lvl && !st_ff.cs_lvl && fcnt_ff == FCNT_DONE;
    wr = fr_end && !in_sr_ff[sbcm_pkg::RO_BIT];
    addr = in_sr_ff[15:sbcm_pkg::ADDR_LSB];
    din = in_sr_ff[DW-1:0];
    ms = din[sbcm_pkg::MS_LSB +: 2];
    ms_wr = wr && addr == sbcm_pkg::A_MODE;
    // Register writes
    if (wr && addr == sbcm_pkg::A_WDS)
    begin
      nxt_st.watchdog_mode_select = din[sbcm_pkg::WMC_BIT];
      nxt_st.wp = din[sbcm_pkg::WP_LSB +: 3];
    end
    if (ms_wr)
    begin
      nxt_st.limp = din[sbcm_pkg::LHC_BIT];
      nxt_st.stbc = din[sbcm_pkg::STBC_LSB +: 3];
    end
    if (wr && addr == sbcm_pkg::A_IEN)
      nxt_st.wken = din[sbcm_pkg::WK_N-1:0];
    // Write one clears a flag; a fresh event wins
    nxt_st.flg = (st_ff.flg & ~((wr && addr == sbcm_pkg::A_IFL) ? din[2:0] : 3'h0)) | wk_evt;
    // Reset width count and readback settle count
    if (st_ff.rcnt != '0)
      nxt_st.rcnt = st_ff.rcnt - 1'b1;
    if (drive)
      nxt_st.settle = sbcm_pkg::SETTLE_CYC;
    else if (st_ff.settle != 2'h0)
      nxt_st.settle = st_ff.settle - 2'h1;
    // Mode transitions
    case (st_ff.mode)
      sbcm_pkg::M_OFF:
      begin
        if (!poff)
        begin
          nxt_st.mode = sbcm_pkg::M_STBY;
          sys_rst = 1'b1;
        end
      end
      sbcm_pkg::M_STBY:
      begin
        if (ota)
        begin
          nxt_st.mode = sbcm_pkg::M_OTP;
          nxt_st.limp = 1'b1;
        end
        else if (ms_wr)
        begin
          nxt_st.msel = ms;
          if (ms == sbcm_pkg::MS_SLP)
            sleep_req = 1'b1;
          else if (ms[1])
          begin
            nxt_st.mode = sbcm_pkg::M_NORM;
            nxt_st.can_en = ms[0];
          end
        end
      end
      sbcm_pkg::M_NORM:
      begin
        if (ota)
        begin
          nxt_st.mode = sbcm_pkg::M_OTP;
          nxt_st.limp = 1'b1;
        end
        else if (ext_rst)
          sys_rst = 1'b1;
        else if (ms_wr)
        begin
          nxt_st.msel = ms;
          if (ms == sbcm_pkg::MS_SLP)
            sleep_req = 1'b1;
          else if (!ms[1])
            nxt_st.mode = sbcm_pkg::M_STBY;
          else
            nxt_st.can_en = ms[0];
        end
      end
      sbcm_pkg::M_SLP:
      begin
        if (|(wk_evt & st_ff.wken))
        begin
          nxt_st.mode = sbcm_pkg::M_STBY;
          sys_rst = 1'b1;
        end
      end
      sbcm_pkg::M_OTP:
      begin
        if (st_ff.lvl[sbcm_pkg::IN_OTR])
        begin
          nxt_st.mode = sbcm_pkg::M_STBY;
          sys_rst = 1'b1;
        end
      end
      default: nxt_st.mode = sbcm_pkg::M_OFF;
    endcase
    // Sleep entry or refusal by short reset
    if (sleep_req)
    begin
      if (sleep_ok)
        nxt_st.mode = sbcm_pkg::M_SLP;
      else
        sys_rst = 1'b1;
    end
    // System reset: back to Standby with defaults
    if (sys_rst)
    begin
      nxt_st.rcnt = RW'(RST_CYC);
      nxt_st.msel = sbcm_pkg::MS_STBY;
      nxt_st.wp = sbcm_pkg::WP_DEF;
      nxt_st.can_en = 1'b0;
      if (nxt_st.mode == sbcm_pkg::M_NORM)
        nxt_st.mode = sbcm_pkg::M_STBY;
    end
    // Battery loss overrides every other mode
    if (poff)
    begin
      nxt_st.mode = sbcm_pkg::M_OFF;
      nxt_st.can_en = 1'b0;
    end
    // Snapshot stays still while the master is selecting
    if (nxt_st.cs_lvl)
    begin
      for (int i = 0; i < sbcm_pkg::N_REGS; i++)
        nxt_st.snap[i * DW +: DW] = reg_rd(st_ff, 3'(i));
    end
  end

  // State register
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_ff <= '0;
      st_ff.mode <= sbcm_pkg::M_OFF;
      st_ff.cs_sy <= 3'h7;
      st_ff.cs_lvl <= 1'b1;
      st_ff.wp <= sbcm_pkg::WP_DEF;
      // Battery counts as low until the pin has really been seen
      st_ff.s1[sbcm_pkg::IN_POFF] <= 1'b1;
      st_ff.s2[sbcm_pkg::IN_POFF] <= 1'b1;
      st_ff.s3[sbcm_pkg::IN_POFF] <= 1'b1;
      st_ff.lvl[sbcm_pkg::IN_POFF] <= 1'b1;
    end
    else
      st_ff <= nxt_st;
  end

  // Regulators follow the mode
  assign main_regulator_en = st_ff.mode == sbcm_pkg::M_STBY || st_ff.mode == sbcm_pkg::M_NORM;
  assign can_regulator_en = st_ff.mode == sbcm_pkg::M_NORM && st_ff.can_en;
  // Transceiver states from their standby bits
  assign can_xcvr_state = xc(st_ff.mode, st_ff.stbc[sbcm_pkg::STBC_CAN]);
  assign lin_one_state = xc(st_ff.mode, st_ff.stbc[sbcm_pkg::STBC_L1]);
  assign lin_two_state = xc(st_ff.mode, st_ff.stbc[sbcm_pkg::STBC_L2]);
  assign bus_hiz = st_ff.mode == sbcm_pkg::M_OFF || st_ff.mode == sbcm_pkg::M_OTP;

  // Watchdog mode from mode, strap pin and mode bit
  always_comb
  begin
    watchdog_mode = sbcm_pkg::WD_OFF;
    if (!st_ff.lvl[sbcm_pkg::IN_WATCHDOG_DISABLE_PIN])
    begin
      if (st_ff.mode == sbcm_pkg::M_STBY)
        watchdog_mode = st_ff.watchdog_mode_select ? sbcm_pkg::WD_OFF : sbcm_pkg::WD_TO;
      else if (st_ff.mode == sbcm_pkg::M_NORM)
        watchdog_mode = st_ff.watchdog_mode_select ? sbcm_pkg::WD_TO : sbcm_pkg::WD_WIN;
    end
  end

  // Reset pin is open drain: only ever pulled low
  assign reset_io_n_o = 1'b0;
  assign reset_io_n_oe_n = ~drive;
  assign interrupt_out_n = ~irq_pend;
  assign watchdog_period = st_ff.wp;
  assign limp_home_n = ~st_ff.limp;
  assign mode_state = st_ff.mode;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);

  // Checks of mode sequencing
  chk_off_battery: assert property (poff |=> st_ff.mode == sbcm_pkg::M_OFF && !main_regulator_en && bus_hiz)
    else $error("battery loss did not reach off mode");
  chk_sleep_wake: assert property ((st_ff.mode == sbcm_pkg::M_SLP && |(wk_evt & st_ff.wken) && !poff)
    |=> st_ff.mode == sbcm_pkg::M_STBY && st_ff.rcnt == RW'(RST_CYC) && st_ff.msel == sbcm_pkg::MS_STBY)
    else $error("wake from sleep mishandled");
  chk_norm_leave: assert property ((st_ff.mode == sbcm_pkg::M_NORM && ms_wr && ms == sbcm_pkg::MS_STBY
    && !ota && !poff && !ext_rst) |=> st_ff.mode == sbcm_pkg::M_STBY)
    else $error("normal did not return to standby");
  chk_stby_outputs: assert property (st_ff.mode == sbcm_pkg::M_STBY |-> main_regulator_en && !can_regulator_en
    && can_xcvr_state == (st_ff.stbc[sbcm_pkg::STBC_CAN] ? sbcm_pkg::XC_LP : sbcm_pkg::XC_OFF))
    else $error("standby outputs wrong");
  chk_norm_lin: assert property (st_ff.mode == sbcm_pkg::M_NORM |->
    lin_one_state == (st_ff.stbc[sbcm_pkg::STBC_L1] ? sbcm_pkg::XC_LP : sbcm_pkg::XC_ACT))
    else $error("lin state wrong in normal");
  chk_sleep_outputs: assert property (st_ff.mode == sbcm_pkg::M_SLP |-> !main_regulator_en && !can_regulator_en
    && !reset_io_n_oe_n && watchdog_mode == sbcm_pkg::WD_OFF)
    else $error("sleep outputs wrong");
  chk_otp_entry: assert property ((st_ff.mode inside {sbcm_pkg::M_STBY, sbcm_pkg::M_NORM} && ota && !poff)
    |=> st_ff.mode == sbcm_pkg::M_OTP && !limp_home_n && !reset_io_n_oe_n && bus_hiz)
    else $error("overtemp entry wrong");
  chk_otp_exit: assert property ((st_ff.mode == sbcm_pkg::M_OTP && st_ff.lvl[sbcm_pkg::IN_OTR] && !poff)
    |=> st_ff.mode == sbcm_pkg::M_STBY && st_ff.rcnt == RW'(RST_CYC))
    else $error("overtemp exit wrong");
  chk_wd_normal: assert property ((st_ff.mode == sbcm_pkg::M_NORM && !st_ff.lvl[sbcm_pkg::IN_WATCHDOG_DISABLE_PIN])
    |-> watchdog_mode == (st_ff.watchdog_mode_select ? sbcm_pkg::WD_TO : sbcm_pkg::WD_WIN))
    else $error("watchdog mode wrong in normal");
  chk_reject_reset: assert property ((sleep_req && !sleep_ok) |=> st_ff.rcnt == RW'(RST_CYC)
    && st_ff.mode != sbcm_pkg::M_SLP ##1 !reset_io_n_oe_n [*8])
    else $error("refused sleep gave no reset");
  chk_reset_count: assert property ((st_ff.rcnt != '0 && !sys_rst) |=> st_ff.rcnt == $past(st_ff.rcnt) - 1'b1)
    else $error("reset width counter slipped");
  chk_period_default: assert property (sys_rst |=> st_ff.wp == sbcm_pkg::WP_DEF)
    else $error("period code not restored");
endmodule

/* File: sbcm_host_model.sv */
// Host controller model acting as serial port master
module sbcm_host_model (
  output logic spi_sclk, // Serial clock
  output logic serial_select_n, // Chip select
  output logic serial_in, // Data to device
  input wire logic serial_out // Data from device
);
  timeunit 1ns;
  timeprecision 100ps;
  // Clock stands low between frames
  initial
  begin
    spi_sclk = 1'b0;
    serial_select_n = 1'b1;
    serial_in = 1'b0;
  end
  // One frame, MSB first; n other than 16 gives a bad frame
  task automatic xfer(input logic [15:0] tx, input int n, output logic [15:0] rx);
    rx = 16'h0000;
    serial_select_n = 1'b0;
    serial_in = tx[15];
    #100;
    for (int i = 0; i < n; i++)
    begin
      spi_sclk = 1'b1;
      #1 serial_in = tx[15 - i];
      #6.5 rx = {rx[14:0], serial_out};
      spi_sclk = 1'b0;
      #7.5;
    end
    #20 serial_select_n = 1'b1;
    // Released line must not look like a held bit
    serial_in = ~serial_in;
  endtask
endmodule

/* File: tb_sbcm_mode_ctrl.sv */
// Self-checking bench for the mode controller
module tb_sbcm_mode_ctrl;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int RST = 20;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic battery_poff = 1'b0, otp_act = 1'b0, otp_rel = 1'b0, can_wake = 1'b0;
  logic wd_pin = 1'b0, loc_wk = 1'b0, lin_wk = 1'b0;
  logic spi_sclk, serial_select_n, serial_in, serial_out, serial_out_en_n;
  logic reset_io_n_i, reset_io_n_o, reset_io_n_oe_n, interrupt_out_n;
  logic main_regulator_en, can_regulator_en, bus_hiz, limp_home_n;
  logic [1:0] can_xcvr_state, lin_one_state, lin_two_state, watchdog_mode;
  logic [2:0] watchdog_period;
  logic [4:0] mode_state;
  logic [11:0] d;
  logic [15:0] rx;
  logic sdo_line;
  logic rst_pull_n = 1'b1;
  int mismatches = 0;
  int comparisons = 0;
  // Reset pin has a pull-up; rst_pull_n stands for another device pulling it
  assign reset_io_n_i = (reset_io_n_oe_n ? 1'b1 : reset_io_n_o) & rst_pull_n;
  // Data line has no pull: a floating output reads inverted
  assign sdo_line = serial_out_en_n ? ~serial_out : serial_out;
  always #10 clk_sys = ~clk_sys;
  sbcm_mode_ctrl #(.RST_CYC(RST)) u_sbcm_mode_ctrl (
    .clk_sys(clk_sys), .arst_n(arst_n), .spi_sclk(spi_sclk), .serial_select_n(serial_select_n),
    .serial_in(serial_in), .serial_out(serial_out), .serial_out_en_n(serial_out_en_n),
    .battery_poff(battery_poff), .otp_act(otp_act), .otp_rel(otp_rel), .watchdog_disable_pin(wd_pin),
    .local_wake(loc_wk), .lin_wake(lin_wk), .can_wake(can_wake), .reset_io_n_i(reset_io_n_i),
    .reset_io_n_o(reset_io_n_o), .reset_io_n_oe_n(reset_io_n_oe_n), .interrupt_out_n(interrupt_out_n),
    .main_regulator_en(main_regulator_en), .can_regulator_en(can_regulator_en),
    .can_xcvr_state(can_xcvr_state), .lin_one_state(lin_one_state), .lin_two_state(lin_two_state),
    .bus_hiz(bus_hiz), .watchdog_mode(watchdog_mode), .watchdog_period(watchdog_period),
    .limp_home_n(limp_home_n), .mode_state(mode_state)
  );
  sbcm_host_model u_sbcm_host_model (
    .spi_sclk(spi_sclk), .serial_select_n(serial_select_n), .serial_in(serial_in), .serial_out(sdo_line)
  );
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Inputs change a little after the rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask
  task automatic wmode(input logic [4:0] m);
    for (int i = 0; i < 200 && mode_state !== m; i++) tick(1);
    chk("mode", 16'(mode_state), 16'(m));
  endtask
  // Gap first, so a caller can watch effects from the commit on
  task automatic xf(input logic [15:0] tx, input int n);
    tick(10);
    u_sbcm_host_model.xfer(tx, n, rx);
  endtask
  task automatic wr(input logic [2:0] a, input logic [11:0] v);
    xf({a, 1'b0, v}, 16);
  endtask
  task automatic rd(input logic [2:0] a);
    xf({a, 1'b1, 12'h000}, 16);
    d = rx[11:0];
  endtask
  // Length of the next low stretch on the reset pin
  task automatic rpulse();
    int c;
    c = 0;
    for (int i = 0; i < 100 && reset_io_n_oe_n !== 1'b0; i++) tick(1);
    while (reset_io_n_oe_n === 1'b0 && c < 1000)
    begin
      tick(1);
      c++;
    end
    chk("reset width", 16'(c >= RST && c < 1000), 16'h0001);
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Hang guard, well beyond the expected run
  initial
  begin
    #400us;
    mismatches++;
    final_report();
  end
  initial
  begin
    tick(20);
    chk("off mode", 16'(mode_state), 16'(sbcm_pkg::M_OFF));
    chk("period", 16'(watchdog_period), 16'h0004);
    arst_n = 1'b1;
    rpulse();
    wmode(sbcm_pkg::M_STBY);
    chk("main reg", 16'(main_regulator_en), 16'h0001);
    chk("can off", 16'(can_xcvr_state), 16'(sbcm_pkg::XC_OFF));
    chk("out float", 16'(serial_out_en_n), 16'h0001);
    chk("wd", 16'(watchdog_mode), 16'(sbcm_pkg::WD_TO));
    rd(sbcm_pkg::A_WDS);
    chk("wds", 16'(d[11:7]), 16'h0008);
    wd_pin = 1'b1;
    tick(10);
    chk("wd pin", 16'(watchdog_mode), 16'(sbcm_pkg::WD_OFF));
    rd(sbcm_pkg::A_WDS);
    chk("wd status", 16'(d[7]), 16'h0001);
    wd_pin = 1'b0;
    $display("test startup done");
    wr(sbcm_pkg::A_WDS, 12'h100);
    tick(10);
    chk("period", 16'(watchdog_period), 16'h0001);
    xf({sbcm_pkg::A_WDS, 1'b1, 12'h200}, 16);
    xf({sbcm_pkg::A_WDS, 1'b0, 12'h500}, 15);
    rd(sbcm_pkg::A_WDS);
    chk("kept", 16'(d[10:8]), 16'h0001);
    wr(sbcm_pkg::A_WDS, 12'h900);
    tick(10);
    chk("wd", 16'(watchdog_mode), 16'(sbcm_pkg::WD_OFF));
    $display("test serial done");
    wr(sbcm_pkg::A_MODE, 12'hC04);
    wmode(sbcm_pkg::M_NORM);
    chk("can reg", 16'(can_regulator_en), 16'h0001);
    chk("can lp", 16'(can_xcvr_state), 16'(sbcm_pkg::XC_LP));
    chk("lin1", 16'(lin_one_state), 16'(sbcm_pkg::XC_ACT));
    chk("lin2", 16'(lin_two_state), 16'(sbcm_pkg::XC_ACT));
    chk("wd", 16'(watchdog_mode), 16'(sbcm_pkg::WD_TO));
    wr(sbcm_pkg::A_MODE, 12'h803);
    tick(10);
    chk("can reg", 16'(can_regulator_en), 16'h0000);
    chk("can act", 16'(can_xcvr_state), 16'(sbcm_pkg::XC_ACT));
    chk("lin1 lp", 16'(lin_one_state), 16'(sbcm_pkg::XC_LP));
    wr(sbcm_pkg::A_MODE, 12'h004);
    wmode(sbcm_pkg::M_STBY);
    chk("can lp", 16'(can_xcvr_state), 16'(sbcm_pkg::XC_LP));
    chk("lin1 off", 16'(lin_one_state), 16'(sbcm_pkg::XC_OFF));
    $display("test modes done");
    wr(sbcm_pkg::A_MODE, 12'h404);
    rpulse();
    chk("mode", 16'(mode_state), 16'(sbcm_pkg::M_STBY));
    wr(sbcm_pkg::A_IEN, 12'h004);
    wr(sbcm_pkg::A_MODE, 12'h404);
    wmode(sbcm_pkg::M_SLP);
    chk("regs", 16'({main_regulator_en, can_regulator_en}), 16'h0000);
    chk("can lp", 16'(can_xcvr_state), 16'(sbcm_pkg::XC_LP));
    chk("lin1 off", 16'(lin_one_state), 16'(sbcm_pkg::XC_OFF));
    chk("wd", 16'(watchdog_mode), 16'(sbcm_pkg::WD_OFF));
    chk("rst low", 16'(reset_io_n_oe_n), 16'h0000);
    can_wake = 1'b1;
    rpulse();
    chk("mode", 16'(mode_state), 16'(sbcm_pkg::M_STBY));
    chk("main reg", 16'(main_regulator_en), 16'h0001);
    chk("period", 16'(watchdog_period), 16'h0004);
    can_wake = 1'b0;
    rd(sbcm_pkg::A_MODE);
    chk("select", 16'(d[11:10]), 16'h0000);
    chk("header", 16'(rx[15:12]), 16'h0002);
    chk("irq", 16'(interrupt_out_n), 16'h0000);
    rd(sbcm_pkg::A_IFL);
    chk("flags", 16'(d), 16'h0004);
    wr(sbcm_pkg::A_MODE, 12'h404);
    rpulse();
    chk("mode", 16'(mode_state), 16'(sbcm_pkg::M_STBY));
    wr(sbcm_pkg::A_IFL, 12'h004);
    tick(10);
    chk("irq", 16'(interrupt_out_n), 16'h0001);
    $display("test sleep done");
    otp_act = 1'b1;
    wmode(sbcm_pkg::M_OTP);
    chk("hiz", 16'({bus_hiz, main_regulator_en}), 16'h0002);
    chk("limp", 16'({limp_home_n, reset_io_n_oe_n, reset_io_n_o}), 16'h0000);
    otp_act = 1'b0;
    otp_rel = 1'b1;
    rpulse();
    chk("mode", 16'(mode_state), 16'(sbcm_pkg::M_STBY));
    otp_rel = 1'b0;
    wr(sbcm_pkg::A_MODE, 12'h800);
    wmode(sbcm_pkg::M_NORM);
    rst_pull_n = 1'b0;
    wmode(sbcm_pkg::M_STBY);
    rst_pull_n = 1'b1;
    rpulse();
    wr(sbcm_pkg::A_MODE, 12'h800);
    wmode(sbcm_pkg::M_NORM);
    otp_act = 1'b1;
    wmode(sbcm_pkg::M_OTP);
    otp_act = 1'b0;
    $display("test overtemp done");
    battery_poff = 1'b1;
    wmode(sbcm_pkg::M_OFF);
    chk("off", 16'({bus_hiz, main_regulator_en}), 16'h0002);
    battery_poff = 1'b0;
    wmode(sbcm_pkg::M_STBY);
    $display("test battery done");
    final_report();
  end
endmodule
